/* hdl/srw_supervisor.sv */
// supervisor top: reset generation, aux monitors, write-protect gating
`timescale 1ns/1ps
module srw_supervisor #(
  parameter int unsigned HOLD_CYC_0 = srw_pkg::HOLD_SEL0_CYC,
  parameter int unsigned HOLD_CYC_1 = srw_pkg::HOLD_SEL1_CYC,
  parameter int unsigned HOLD_CYC_2 = srw_pkg::HOLD_SEL2_CYC,
  parameter int unsigned HOLD_CYC_3 = srw_pkg::HOLD_SEL3_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // supply and manual reset
  input wire logic supply_ok,
  input wire logic manual_reset_in,
  // hold time select
  input wire logic reset_timeout_sel_hi,
  input wire logic reset_timeout_sel_lo,
  // reset output pin, open drain
  output logic reset_out,
  output logic reset_pin_o,
  output logic reset_pin_oe_n,
  // aux monitor comparator results
  input wire logic aux_monitor_a_input,
  input wire logic aux_monitor_b_input,
  // aux monitor pins, open drain
  output logic aux_monitor_a_out,
  output logic aux_monitor_b_out,
  output logic aux_monitor_a_oe_n,
  output logic aux_monitor_b_oe_n,
  // latched monitor status
  input wire srw_pkg::srw_mon_t status_clear,
  output srw_pkg::srw_mon_t status_o,
  // write-protect gating
  input wire logic wp_pin_in,
  input wire logic wp_pin_driven,
  input wire logic [1:0] block_protect,
  input wire srw_pkg::srw_wr_req_t wr_req,
  output logic write_grant,
  output logic write_refused
);
  import srw_pkg::*;

  // ***********************************************
  // reset request sources
  // ***********************************************
  logic por_pending_r;
  logic por_pending_nxt;
  logic any_req;

  // power-up request clears the first time the supply is good
  always_comb begin
    por_pending_nxt = por_pending_r && !supply_ok;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      por_pending_r <= POR_PENDING_RST;
    end else if (clk_en) begin
      por_pending_r <= por_pending_nxt;
    end
  end

  // power-up, undervoltage and manual requests merge into one
  assign any_req = por_pending_r || !supply_ok || manual_reset_in;

  // ***********************************************
  // hold time select and shared counter
  // ***********************************************
  logic [HOLD_CNT_W-1:0] hold_load;
  logic [HOLD_CNT_W-1:0] hold_cnt;
  logic hold_done;

  // one less than the count so the hold lasts exactly that many cycles
  always_comb begin
    unique case ({reset_timeout_sel_hi, reset_timeout_sel_lo})
      2'h0: hold_load = HOLD_CNT_W'(HOLD_CYC_0 - 1);
      2'h1: hold_load = HOLD_CNT_W'(HOLD_CYC_1 - 1);
      2'h2: hold_load = HOLD_CNT_W'(HOLD_CYC_2 - 1);
      2'h3: hold_load = HOLD_CNT_W'(HOLD_CYC_3 - 1);
    endcase
  end

  // select is taken live; a change mid-hold only acts on next restart
  srw_hold_timer #(
    .W(HOLD_CNT_W)
  ) u_timer (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .restart(any_req),
    .load_val(hold_load),
    .count(hold_cnt),
    .done(hold_done)
  );

  // ***********************************************
  // reset output state machine
  // ***********************************************
  srw_rst_state_t state_r;
  srw_rst_state_t state_nxt;
  logic reset_out_r;
  logic reset_out_nxt;

  // any request asserts; release only after a full quiet hold period
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RST_ASSERT: begin
        if (!any_req) begin
          state_nxt = RST_HOLD;
        end
      end
      RST_HOLD: begin
        if (any_req) begin
          state_nxt = RST_ASSERT;
        end else if (hold_done) begin
          state_nxt = RST_IDLE;
        end
      end
      RST_IDLE: begin
        if (any_req) begin
          state_nxt = RST_ASSERT;
        end
      end
    endcase
    reset_out_nxt = (state_nxt != RST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= RST_ASSERT;
      reset_out_r <= RESET_OUT_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
      reset_out_r <= reset_out_nxt;
    end
  end

  // open drain: pull low when idle, release so the pull-up shows high
  assign reset_out = reset_out_r;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n = reset_out_r;

  // ***********************************************
  // aux monitors
  // ***********************************************
  logic aux_a_r;
  logic aux_b_r;
  logic aux_a_nxt;
  logic aux_b_nxt;
  srw_mon_t alarm;
  logic [MON_CHANNELS-1:0] status_bits;

  // only the output flop, no power-up or timeout stage
  always_comb begin
    aux_a_nxt = aux_monitor_a_input;
    aux_b_nxt = aux_monitor_b_input;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      aux_a_r <= AUX_OUT_RST;
      aux_b_r <= AUX_OUT_RST;
    end else if (clk_en) begin
      aux_a_r <= aux_a_nxt;
      aux_b_r <= aux_b_nxt;
    end
  end

  // high above trip, driven low below
  assign aux_monitor_a_out = aux_a_r;
  assign aux_monitor_b_out = aux_b_r;
  assign aux_monitor_a_oe_n = aux_a_r;
  assign aux_monitor_b_oe_n = aux_b_r;

  // a low monitor state is the alarm that gets latched
  assign alarm.a = !aux_monitor_a_input;
  assign alarm.b = !aux_monitor_b_input;

  srw_mon_latch #(
    .N(MON_CHANNELS)
  ) u_latch (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .alarm(alarm),
    .clear(status_clear),
    .status(status_bits)
  );

  assign status_o = srw_mon_t'(status_bits);

  // ***********************************************
  // write-protect gating
  // ***********************************************
  logic wp_active;
  logic block_locked;
  logic refuse;
  logic grant_r;
  logic refused_r;
  logic grant_nxt;
  logic refused_nxt;

  // an undriven pin counts as low, like the internal pull-down
  assign wp_active = wp_pin_driven && wp_pin_in;
  assign block_locked = (block_protect != BLOCK_PROT_NONE);
  assign refuse = wp_active && (wr_req.nonvolatile || block_locked);

  // verdict is a one-cycle pulse the cycle after the request
  always_comb begin
    grant_nxt = wr_req.valid && !refuse;
    refused_nxt = wr_req.valid && refuse;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      grant_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (clk_en) begin
      grant_r <= grant_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign write_grant = grant_r;
  assign write_refused = refused_r;

  // ***********************************************
  // assertions
  // ***********************************************
  sequence hold_quiet_s;
    clk_en && state_r == RST_HOLD && !any_req;
  endsequence

  sequence hold_end_s;
    hold_quiet_s ##0 hold_done;
  endsequence

  mr_assert_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && manual_reset_in |=> reset_out_r)
    else $error("manual reset did not assert reset output");

  hold_keep_a: assert property (@(posedge mclk) disable iff (reset)
    state_r == RST_HOLD && !hold_done |=> reset_out_r)
    else $error("reset output dropped before hold expired");

  sel_load_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && any_req |=> hold_cnt == $past(hold_load))
    else $error("hold counter not loaded from select");

  nv_refuse_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && wr_req.valid && wr_req.nonvolatile && wp_active
    |=> write_refused && !write_grant)
    else $error("nonvolatile write not refused");

  lock_refuse_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && wr_req.valid && wp_active && block_locked
    |=> write_refused && !write_grant)
    else $error("locked write not refused");

  wp_float_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && wr_req.valid && !wp_pin_driven |=> write_grant)
    else $error("floating write protect blocked a write");

  por_hold_a: assert property (@(posedge mclk) disable iff (reset)
    por_pending_r |-> reset_out_r)
    else $error("reset released during power-up");

  uv_assert_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && !supply_ok |=> reset_out_r ##0 state_r == RST_ASSERT)
    else $error("undervoltage did not assert reset");

  aux_a_follow_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en |=> aux_monitor_a_out == $past(aux_monitor_a_input) && aux_monitor_a_oe_n == aux_monitor_a_out)
    else $error("aux monitor a output not following input");

  aux_b_follow_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en |=> aux_monitor_b_out == $past(aux_monitor_b_input))
    else $error("aux monitor b output not following input");

  alarm_latch_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && alarm.a |=> status_o.a)
    else $error("alarm not latched");

  status_sticky_a: assert property (@(posedge mclk) disable iff (reset)
    status_o.b && !(clk_en && status_clear.b) |=> status_o.b)
    else $error("latched status lost without clear");

  hold_release_a: assert property (@(posedge mclk) disable iff (reset)
    hold_end_s |=> !reset_out_r)
    else $error("reset not released after hold");

  hold_restart_a: assert property (@(posedge mclk) disable iff (reset)
    hold_quiet_s ##1 (clk_en && any_req) |=> state_r == RST_ASSERT && reset_out_r)
    else $error("hold not restarted by new request");
endmodule

/* hdl/srw_pkg.sv */
// package: constants and types of the supervisor, reset and write-protect block
package srw_pkg;

  // ***********************************************
  // clock and hold-time constants
  // ***********************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1_000;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S;

  // selectable reset hold times, milliseconds, by {sel_hi, sel_lo}
  localparam int unsigned HOLD_SEL0_MS = 50;
  localparam int unsigned HOLD_SEL1_MS = 100;
  localparam int unsigned HOLD_SEL2_MS = 200;
  localparam int unsigned HOLD_SEL3_MS = 300;

  // cycle counts derived from the times above
  localparam int unsigned HOLD_SEL0_CYC = HOLD_SEL0_MS * CYC_PER_MS;
  localparam int unsigned HOLD_SEL1_CYC = HOLD_SEL1_MS * CYC_PER_MS;
  localparam int unsigned HOLD_SEL2_CYC = HOLD_SEL2_MS * CYC_PER_MS;
  localparam int unsigned HOLD_SEL3_CYC = HOLD_SEL3_MS * CYC_PER_MS;

  // wide enough for the longest hold count
  localparam int unsigned HOLD_CNT_W = 25;

  // ***********************************************
  // reset values and field codes
  // ***********************************************
  localparam logic RESET_OUT_RST = 1'b1;
  localparam logic POR_PENDING_RST = 1'b1;
  localparam logic AUX_OUT_RST = 1'b0;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] BLOCK_PROT_NONE = 2'h0;
  localparam int unsigned MON_CHANNELS = 2;

  // ***********************************************
  // types
  // ***********************************************
  typedef struct packed {
    logic b;
    logic a;
  } srw_mon_t;

  typedef struct packed {
    logic valid;
    logic nonvolatile;
  } srw_wr_req_t;

  typedef enum logic [2:0] {
    RST_ASSERT = 3'b001,
    RST_HOLD = 3'b010,
    RST_IDLE = 3'b100
  } srw_rst_state_t;

endpackage

/* hdl/srw_hold_timer.sv */
// down counter that times the reset hold period
`timescale 1ns/1ps
module srw_hold_timer #(
  parameter int unsigned W = 25
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic restart,
  input wire logic [W-1:0] load_val,
  // status
  output logic [W-1:0] count,
  output logic done
);
  import srw_pkg::*;

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // reload while a request stands, count down after it goes
  always_comb begin
    cnt_nxt = cnt_r;
    if (restart) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign done = (cnt_r == '0) && !restart;
endmodule

/* hdl/srw_mon_latch.sv */
// sticky alarm bits, one per monitor channel
`timescale 1ns/1ps
module srw_mon_latch #(
  parameter int unsigned N = 2
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // events and clears
  input wire logic [N-1:0] alarm,
  input wire logic [N-1:0] clear,
  // latched state
  output logic [N-1:0] status
);
  import srw_pkg::*;

  logic [N-1:0] st_r;
  logic [N-1:0] st_nxt;

  // set beats clear so an alarm in the clear cycle is kept
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      if (alarm[i]) begin
        st_nxt[i] = 1'b1;
      end else if (clear[i]) begin
        st_nxt[i] = 1'b0;
      end
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (reset) begin
          st_r[g] <= 1'b0;
        end else if (clk_en) begin
          st_r[g] <= st_nxt[g];
        end
      end
    end
  endgenerate

  assign status = st_r;
endmodule

/* bench/srw_proc_model.sv */
// processor model that sits on the far side of the open-drain reset pin
`timescale 1ns/1ps
module srw_proc_model (
  // clock
  input wire logic mclk,
  // open-drain reset pin
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_n,
  // what the processor sees
  output logic in_reset,
  output int unsigned n_boots
);
  logic prev_r;
  // the pull-up shows high once the pin is released
  assign in_reset = reset_pin_oe_n ? 1'b1 : reset_pin_o;
  initial begin
    n_boots = 0;
    prev_r = 1'b0;
  end
  // one boot per release; an unknown pin before reset never counts
  always @(posedge mclk) begin
    if (in_reset === 1'b0 && prev_r === 1'b1) begin
      n_boots <= n_boots + 1;
    end
    prev_r <= in_reset;
  end
endmodule

/* bench/test_srw_supervisor.sv */
// testbench of the supervisor: reset timing, monitors and write gate
`timescale 1ns/1ps
module test_srw_supervisor;
  import srw_pkg::*;
  // short hold counts keep the run brief
  localparam int unsigned HOLD_TBL [4] = '{10, 20, 40, 60};
  logic mclk, reset, clk_en, supply_ok, manual_reset_in;
  logic reset_timeout_sel_hi, reset_timeout_sel_lo;
  logic reset_out, reset_pin_o, reset_pin_oe_n, in_reset;
  logic aux_monitor_a_input, aux_monitor_b_input, aux_monitor_a_out, aux_monitor_b_out;
  logic aux_monitor_a_oe_n, aux_monitor_b_oe_n;
  srw_mon_t status_clear, status_o, st_exp;
  logic wp_pin_in, wp_pin_driven, write_grant, write_refused;
  logic [1:0] block_protect, mon_exp, wr_exp;
  srw_wr_req_t wr_req;
  logic [31:0] r;
  int unsigned n_boots;
  int seed, err_count, n_compared;

  srw_supervisor #(.HOLD_CYC_0(HOLD_TBL[0]), .HOLD_CYC_1(HOLD_TBL[1]), .HOLD_CYC_2(HOLD_TBL[2]),
    .HOLD_CYC_3(HOLD_TBL[3])) u_srw_supervisor (.mclk, .reset, .clk_en, .supply_ok, .manual_reset_in,
    .reset_timeout_sel_hi, .reset_timeout_sel_lo, .reset_out, .reset_pin_o, .reset_pin_oe_n,
    .aux_monitor_a_input, .aux_monitor_b_input, .aux_monitor_a_out, .aux_monitor_b_out,
    .aux_monitor_a_oe_n, .aux_monitor_b_oe_n, .status_clear, .status_o, .wp_pin_in, .wp_pin_driven,
    .block_protect, .wr_req, .write_grant, .write_refused);
  srw_proc_model u_srw_proc_model (.mclk, .reset_pin_o, .reset_pin_oe_n, .in_reset, .n_boots);

  // ***********************************************
  // shared tasks
  // ***********************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a floating pin counts as low, so only a driven high pin protects
  function automatic logic refuse(logic wp, logic drv, logic [1:0] bp, logic nv);
    return (wp & drv) & (nv | (bp != BLOCK_PROT_NONE));
  endfunction

  // request already dropped; count cycles until reset_out drops and the reset pin is pulled low
  task automatic hold_check(input int unsigned len, input string what);
    int unsigned n;
    n = 0;
    while (reset_out === 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check(what, 32'(n >= len && n <= len + 3), 32'h1);
    $display("test %s done", what);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run of about six hundred cycles
  initial begin
    #100_000;
    err_count++;
    stop_test();
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    seed = 32'h64EC2E05;
    err_count = 0;
    n_compared = 0;
    {reset, clk_en, supply_ok, manual_reset_in} = 4'hC;
    {reset_timeout_sel_hi, reset_timeout_sel_lo} = 2'h0;
    {aux_monitor_a_input, aux_monitor_b_input} = 2'h3;
    {wp_pin_in, wp_pin_driven, block_protect} = 4'h0;
    status_clear = '0;
    wr_req = '0;
    st_exp = '0;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    supply_ok = 1'b1;
    hold_check(HOLD_TBL[0], "powerup");
    // every select code, from the shortest to the longest hold
    for (int s = 0; s < 4; s++) begin
      {reset_timeout_sel_hi, reset_timeout_sel_lo} = 2'(s);
      manual_reset_in = 1'b1;
      @(negedge mclk);
      check("manual rise", reset_out, 1'b1);
      repeat (3) @(negedge mclk);
      manual_reset_in = 1'b0;
      hold_check(HOLD_TBL[s], "manual");
    end
    // brownout, then a new request in mid hold restarts the full count
    {reset_timeout_sel_hi, reset_timeout_sel_lo} = 2'h1;
    supply_ok = 1'b0;
    repeat (5) @(negedge mclk);
    check("brownout", reset_out, 1'b1);
    supply_ok = 1'b1;
    repeat (HOLD_TBL[1] / 2) @(negedge mclk);
    manual_reset_in = 1'b1;
    @(negedge mclk);
    manual_reset_in = 1'b0;
    hold_check(HOLD_TBL[1], "restart");
    // the model counts the last release one edge later
    @(negedge mclk);
    check("boots", n_boots, 32'd6);
    // enable low: a request and a monitor low must not register
    clk_en = 1'b0;
    manual_reset_in = 1'b1;
    aux_monitor_a_input = 1'b0;
    repeat (3) @(negedge mclk);
    check("freeze", {reset_out, aux_monitor_a_out, status_o}, 4'h4);
    manual_reset_in = 1'b0;
    aux_monitor_a_input = 1'b1;
    clk_en = 1'b1;
    $display("test freeze done");
    // first 32 cycles walk every protect combination, then random traffic
    for (int i = 0; i < 400; i++) begin
      if (i > 0) begin
        check("monitor", {aux_monitor_a_out, aux_monitor_b_out, status_o}, {mon_exp, st_exp});
        check("aux pins", {aux_monitor_a_oe_n, aux_monitor_b_oe_n}, mon_exp);
        check("write", {write_grant, write_refused}, wr_exp);
        check("reset pin", {in_reset, reset_out}, 2'h0);
      end
      r = $random(seed);
      {wp_pin_in, wp_pin_driven, block_protect, wr_req.nonvolatile} = (i < 32) ? 5'(i) : r[4:0];
      wr_req.valid = (i < 32) | r[5];
      aux_monitor_a_input = |r[7:6];
      aux_monitor_b_input = |r[9:8];
      status_clear = r[11:10];
      mon_exp = {aux_monitor_a_input, aux_monitor_b_input};
      // set wins over clear in the same cycle
      st_exp.a = ~aux_monitor_a_input | (st_exp.a & ~status_clear.a);
      st_exp.b = ~aux_monitor_b_input | (st_exp.b & ~status_clear.b);
      wr_exp[0] = wr_req.valid & refuse(wp_pin_in, wp_pin_driven, block_protect, wr_req.nonvolatile);
      wr_exp[1] = wr_req.valid & ~wr_exp[0];
      @(negedge mclk);
    end
    $display("test random traffic done");
    stop_test();
  end
endmodule
